// *** pkg/urx_pkg.sv ***
// shared constants for the serial receiver with baud generator
// assumes an apb master with 32-bit data and byte addresses
package urx_pkg;
	// register byte addresses
	localparam logic [7:0] URX_OFS_BAUD = 8'h00;
	localparam logic [7:0] URX_OFS_STATUS = 8'h04;
	localparam logic [7:0] URX_OFS_MODE = 8'h08;
	localparam logic [7:0] URX_OFS_DATA = 8'h0C;
	// status bit positions
	localparam int URX_ST_AVAIL = 0;
	localparam int URX_ST_OVR = 1;
	localparam int URX_ST_RX_FRAMING_ERROR = 2;
	localparam int URX_ST_RX_PARITY_ERROR = 3;
	localparam int URX_ST_IDLE = 4;
	localparam int URX_ST_ADDR = 5;
	localparam int URX_ST_SEL = 6;
	// mode bit positions
	localparam int URX_MD_STOP = 0;
	localparam int URX_MD_DPS = 1;
	localparam int URX_MD_LOOP = 3;
	// data width and parity encodings
	localparam logic [1:0] URX_DPS_8E = 2'h1;
	localparam logic [1:0] URX_DPS_8O = 2'h2;
	localparam logic [1:0] URX_DPS_9N = 2'h3;
	// interrupt select encodings
	localparam logic [1:0] URX_SEL_THREE = 2'h2;
	localparam logic [1:0] URX_SEL_FULL = 2'h3;
	localparam int URX_THR_THREE = 3;
	// buffer entry layout: data, framing, parity
	localparam int URX_ENT_RX_FRAMING_ERROR = 9;
	localparam int URX_ENT_RX_PARITY_ERROR = 10;
	localparam int URX_ENT_W = 11;
	localparam int URX_FIFO_DEPTH = 4;
	// oversampling: sixteen ticks per bit, sample at the middle
	localparam logic [3:0] URX_PH_MID = 4'h7;
	localparam logic [3:0] URX_PH_LAST = 4'hF;
	localparam logic [3:0] URX_BITS_8 = 4'h7;
	localparam logic [3:0] URX_BITS_9 = 4'h8;
	localparam logic [15:0] URX_BAUD_RST = 16'h0000;
	typedef enum logic [2:0] {
		URX_IDLE, URX_START, URX_DATA, URX_PAR, URX_STOP1, URX_STOP2, URX_BRK_WAIT
	} urx_rx_state_t;
endpackage : urx_pkg

// *** hdl/urx_top.sv ***
// serial receive path with 16-bit baud generator, four-word buffer and apb registers
// assumes clk_i is the instruction clock and tx_loop_i comes from the local transmitter
`timescale 1ns/100ps
// What this block does
// R1 - four-entry receive buffer holds up to four words; a word finished while it is full is dropped
// R2 - data available status reads 1 while buffer is not empty
// R3 - reading an empty buffer returns stale data and moves nothing
// R4 - each data read of a non-empty buffer pops; error flags follow the new head word
// R5 - reset empties the buffer
// R6 - select 00 or 01 interrupts on every buffer transfer outside address mode
// R7 - select 10 interrupts when a transfer leaves three words
// R8 - select 11 interrupts when a transfer fills the buffer
// R9 - overrun sets when full buffer meets a finished word at stop
// R10 - while overrun is set no new data is shifted in
// R11 - software checks and clears overrun; hardware only clears on reset
// R12 - framing error when any configured stop bit samples low
// R13 - framing and parity flags are read-only, stored per word, reset cleared
// R14 - parity error on wrong parity, only in odd or even mode
// R15 - idle status low from start detect to stop completion
// R16 - frame length comes from data/parity select and stop select
// R17 - long break ends as zero word with framing error and interrupt
// R18 - after a break wait for high line before hunting a start bit
// R19 - address mode: ninth bit set marks address and always interrupts
// R20 - loopback feeds receiver from internal transmit output
// R21 - software configures mode, then loopback, then enables transmit
// R22 - divisor 0..65535 gives bit rate clock over sixteen times divisor plus one
// R23 - sixteen ticks per bit find the start edge and centre sample
module urx_top import urx_pkg::*; #(
	parameter int DEPTH = URX_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic pslverr_o,
	output logic [31:0] prdata_o,
	// serial line
	input wire logic rx_pin_i,
	input wire logic tx_loop_i,
	// receive interrupt edge
	output logic rx_irq_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
	localparam logic [CW-1:0] THREE_C = CW'(URX_THR_THREE);
	localparam logic [PW-1:0] LASTP_C = PW'(DEPTH - 1);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic [15:0] baud;
		logic [15:0] bcnt;
		logic tick;
		logic [1:0] sel;
		logic addr_en;
		logic ovr;
		logic stop2;
		logic [1:0] dps;
		logic loop;
		urx_rx_state_t st;
		logic [3:0] ph;
		logic [3:0] bitn;
		logic [8:0] shf;
		logic par;
		logic rx_parity_error;
		logic rx_framing_error;
		logic [DEPTH-1:0][URX_ENT_W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
	} urx_state_t;

	urx_state_t s_ff;
	urx_state_t nxt_s;
	logic acc_w, done_w, push_w, pop_w, frame_end_w, line_w, full_w;
	logic [URX_ENT_W-1:0] head_w;
	logic [URX_ENT_W-1:0] last_w;
	logic [PW-1:0] prevp_w;
	logic [CW-1:0] cnt_new_w;

	// head entry and line selection
	assign head_w = s_ff.mem[s_ff.rp];
	assign prevp_w = (s_ff.rp == '0) ? LASTP_C : s_ff.rp - 1'b1; // slot of the word read last
	assign last_w = s_ff.mem[prevp_w];
	assign line_w = s_ff.loop ? tx_loop_i : s_ff.sync2; // [R20]
	assign acc_w = psel_i & penable_i;
	assign done_w = acc_w & s_ff.pready;

	// next-state logic for bus, baud generator, receiver and buffer
	always_comb begin
		logic rx_framing_error_now;
		logic [3:0] last_bit;
		rx_framing_error_now = 1'b0;
		nxt_s = s_ff;
		push_w = 1'b0;
		pop_w = 1'b0;
		frame_end_w = 1'b0;
		full_w = 1'b0;
		cnt_new_w = s_ff.cnt;
		last_bit = (s_ff.dps == URX_DPS_9N) ? URX_BITS_9 : URX_BITS_8; // [R16]
		// two-stage pin synchroniser
		nxt_s.sync1 = rx_pin_i;
		nxt_s.sync2 = s_ff.sync1;
		// baud tick at sixteen times the bit rate
		if (s_ff.bcnt == 16'h0000) begin
			nxt_s.bcnt = s_ff.baud; // [R22]
			nxt_s.tick = 1'b1;
		end else begin
			nxt_s.bcnt = s_ff.bcnt - 16'h0001;
			nxt_s.tick = 1'b0;
		end
		// apb: one wait state, answer registered
		nxt_s.pready = acc_w & ~s_ff.pready;
		nxt_s.pslverr = 1'b0;
		if (acc_w && !s_ff.pready) begin
			nxt_s.prdata = 32'h0000_0000;
			case (paddr_i)
				URX_OFS_BAUD: nxt_s.prdata[15:0] = s_ff.baud;
				URX_OFS_STATUS: begin
					nxt_s.prdata[URX_ST_AVAIL] = (s_ff.cnt != '0); // [R2]
					nxt_s.prdata[URX_ST_OVR] = s_ff.ovr;
					nxt_s.prdata[URX_ST_RX_FRAMING_ERROR] = (s_ff.cnt != '0) & head_w[URX_ENT_RX_FRAMING_ERROR]; // [R13]
					nxt_s.prdata[URX_ST_RX_PARITY_ERROR] = (s_ff.cnt != '0) & head_w[URX_ENT_RX_PARITY_ERROR];
					nxt_s.prdata[URX_ST_IDLE] = (s_ff.st == URX_IDLE) | (s_ff.st == URX_BRK_WAIT); // [R15]
					nxt_s.prdata[URX_ST_ADDR] = s_ff.addr_en;
					nxt_s.prdata[URX_ST_SEL+:2] = s_ff.sel;
				end
				URX_OFS_MODE: begin
					nxt_s.prdata[URX_MD_STOP] = s_ff.stop2;
					nxt_s.prdata[URX_MD_DPS+:2] = s_ff.dps;
					nxt_s.prdata[URX_MD_LOOP] = s_ff.loop;
				end
				URX_OFS_DATA: begin
					// an empty buffer shows the word read last and moves nothing
					nxt_s.prdata[8:0] = (s_ff.cnt != '0) ? head_w[8:0] : last_w[8:0]; // [R3]
				end
				default: nxt_s.pslverr = 1'b1;
			endcase
		end
		// register writes take effect at the completing edge
		if (done_w && pwrite_i) begin
			case (paddr_i)
				URX_OFS_BAUD: begin
					nxt_s.baud = pwdata_i[15:0];
					nxt_s.bcnt = pwdata_i[15:0]; // new rate applies at once [R22]
				end
				URX_OFS_STATUS: begin
					nxt_s.sel = pwdata_i[URX_ST_SEL+:2];
					nxt_s.addr_en = pwdata_i[URX_ST_ADDR];
					if (!pwdata_i[URX_ST_OVR])
						nxt_s.ovr = 1'b0; // [R11]
				end
				URX_OFS_MODE: begin
					nxt_s.stop2 = pwdata_i[URX_MD_STOP];
					nxt_s.dps = pwdata_i[URX_MD_DPS+:2];
					nxt_s.loop = pwdata_i[URX_MD_LOOP];
				end
				default: ;
			endcase
		end
		// data read pops only when something is buffered
		if (done_w && !pwrite_i && paddr_i == URX_OFS_DATA && s_ff.cnt != '0) begin
			pop_w = 1'b1; // [R4]
			nxt_s.rp = (s_ff.rp == LASTP_C) ? '0 : s_ff.rp + 1'b1;
		end
		// receiver, advanced on each baud tick
		if (s_ff.tick) begin
			nxt_s.ph = s_ff.ph + 4'h1;
			case (s_ff.st)
				URX_IDLE: begin
					if (!s_ff.ovr && !line_w) begin // [R10]
						nxt_s.st = URX_START; // [R23]
						nxt_s.ph = 4'h0;
					end
				end
				URX_START: begin
					if (s_ff.ph == URX_PH_MID && line_w)
						nxt_s.st = URX_IDLE; // glitch, not a start bit
					else if (s_ff.ph == URX_PH_LAST) begin
						nxt_s.st = URX_DATA;
						nxt_s.bitn = 4'h0;
						nxt_s.shf = 9'h000;
						nxt_s.par = 1'b0;
						nxt_s.rx_parity_error = 1'b0;
						nxt_s.rx_framing_error = 1'b0;
					end
				end
				URX_DATA: begin
					if (s_ff.ph == URX_PH_MID) begin
						nxt_s.shf[s_ff.bitn] = line_w; // [R23]
						nxt_s.par = s_ff.par ^ line_w;
					end else if (s_ff.ph == URX_PH_LAST) begin
						if (s_ff.bitn != last_bit)
							nxt_s.bitn = s_ff.bitn + 4'h1;
						else if (s_ff.dps == URX_DPS_8E || s_ff.dps == URX_DPS_8O)
							nxt_s.st = URX_PAR; // [R16]
						else
							nxt_s.st = URX_STOP1;
					end
				end
				URX_PAR: begin
					if (s_ff.ph == URX_PH_MID)
						nxt_s.rx_parity_error = (s_ff.par ^ line_w) ^ (s_ff.dps == URX_DPS_8O); // [R14]
					else if (s_ff.ph == URX_PH_LAST)
						nxt_s.st = URX_STOP1;
				end
				URX_STOP1: begin
					if (s_ff.ph == URX_PH_MID) begin
						nxt_s.rx_framing_error = ~line_w; // [R12]
						if (!s_ff.stop2) begin
							frame_end_w = 1'b1;
							rx_framing_error_now = ~line_w;
						end
					end else if (s_ff.ph == URX_PH_LAST)
						nxt_s.st = URX_STOP2;
				end
				URX_STOP2: begin
					if (s_ff.ph == URX_PH_MID) begin
						frame_end_w = 1'b1;
						rx_framing_error_now = s_ff.rx_framing_error | ~line_w; // [R12]
					end
				end
				URX_BRK_WAIT: begin
					if (line_w)
						nxt_s.st = URX_IDLE; // [R18]
				end
				default: nxt_s.st = URX_IDLE;
			endcase
		end
		// frame complete: transfer into buffer or flag overrun
		if (frame_end_w) begin
			nxt_s.rx_framing_error = rx_framing_error_now;
			nxt_s.st = line_w ? URX_IDLE : URX_BRK_WAIT; // [R17] [R18]
			full_w = (s_ff.cnt == FULL_C) && !pop_w;
			if (full_w)
				nxt_s.ovr = 1'b1; // [R9]
			else begin
				push_w = 1'b1;
				nxt_s.mem[s_ff.wp] = {s_ff.rx_parity_error, rx_framing_error_now, s_ff.shf}; // [R13] [R17]
				nxt_s.wp = (s_ff.wp == LASTP_C) ? '0 : s_ff.wp + 1'b1;
			end
		end
		// occupancy and interrupt edge
		cnt_new_w = s_ff.cnt + CW'(push_w) - CW'(pop_w); // [R1]
		nxt_s.cnt = cnt_new_w;
		nxt_s.irq = 1'b0;
		if (push_w) begin
			if (s_ff.addr_en && s_ff.dps == URX_DPS_9N)
				nxt_s.irq = s_ff.shf[8]; // [R19]
			else if (s_ff.sel == URX_SEL_THREE)
				nxt_s.irq = (cnt_new_w == THREE_C); // [R7]
			else if (s_ff.sel == URX_SEL_FULL)
				nxt_s.irq = (cnt_new_w == FULL_C); // [R8]
			else
				nxt_s.irq = 1'b1; // [R6]
		end
	end

	// state register; reset empties the buffer and clears all flags
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_ff <= '0; // [R5]
			s_ff.baud <= URX_BAUD_RST;
			s_ff.sync1 <= 1'b1; // line idles high: no false start bit after reset
			s_ff.sync2 <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// outputs straight from flops
	assign pready_o = s_ff.pready;
	assign pslverr_o = s_ff.pslverr;
	assign prdata_o = s_ff.prdata;
	assign rx_irq_o = s_ff.irq;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// buffer never exceeds its depth
	a_fifo_bound: assert property (s_ff.cnt <= FULL_C) // [R1]
		else $error("buffer count above depth");

	// empty read leaves the read pointer alone
	a_empty_read: assert property (done_w && !pwrite_i && paddr_i == URX_OFS_DATA
		&& s_ff.cnt == '0 |=> $stable(s_ff.rp)) // [R3]
		else $error("empty read moved the buffer");

	// a read of a non-empty buffer advances the head
	a_pop_moves: assert property (done_w && !pwrite_i && paddr_i == URX_OFS_DATA
		&& s_ff.cnt != '0 |=> s_ff.rp != $past(s_ff.rp)) // [R4]
		else $error("data read did not pop");

	sequence push_plain_s(logic [1:0] v);
		push_w && !(s_ff.addr_en && s_ff.dps == URX_DPS_9N) && s_ff.sel == v;
	endsequence

	a_irq_three: assert property (push_plain_s(URX_SEL_THREE) |=> rx_irq_o == (s_ff.cnt == THREE_C)) // [R7]
		else $error("threshold three interrupt wrong");

	a_irq_full: assert property (push_plain_s(URX_SEL_FULL) |=> rx_irq_o == (s_ff.cnt == FULL_C)) // [R8]
		else $error("full interrupt wrong");

	a_irq_every: assert property (push_w && !(s_ff.addr_en && s_ff.dps == URX_DPS_9N)
		&& !s_ff.sel[1] |=> rx_irq_o) // [R6]
		else $error("missing per-word interrupt");

	a_irq_cause: assert property (rx_irq_o |-> $past(push_w)) // [R19]
		else $error("interrupt without a transfer");

	a_overrun_set: assert property (frame_end_w && s_ff.cnt == FULL_C && !pop_w
		|=> s_ff.ovr && s_ff.cnt == FULL_C) // [R9]
		else $error("overrun not flagged");

	a_overrun_stall: assert property (s_ff.ovr && s_ff.st == URX_IDLE |=> s_ff.st == URX_IDLE) // [R10]
		else $error("reception started during overrun");

	a_break_hold: assert property (s_ff.st == URX_BRK_WAIT && !line_w |=> s_ff.st == URX_BRK_WAIT) // [R18]
		else $error("low line taken as start after break");

	sequence start_glitch_s;
		s_ff.st == URX_START && s_ff.tick && s_ff.ph == URX_PH_MID && line_w;
	endsequence

	a_start_reject: assert property (start_glitch_s |=> s_ff.st == URX_IDLE) // [R23]
		else $error("false start bit accepted");

	a_baud_reload: assert property (s_ff.tick && $stable(s_ff.baud) |-> s_ff.bcnt == s_ff.baud) // [R22]
		else $error("baud counter not reloaded");

	// the interrupt edge lasts exactly one cycle
	a_irq_pulse: assert property (rx_irq_o |=> !rx_irq_o) // [R6]
		else $error("interrupt longer than one cycle");

	// bus answer lasts one cycle and carries any error with it
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("pready held too long");

	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("slave error without pready");

	// only a software write of zero clears the overrun flag
	a_overrun_keep: assert property (s_ff.ovr && !(done_w && pwrite_i && paddr_i == URX_OFS_STATUS
		&& !pwdata_i[URX_ST_OVR]) |=> s_ff.ovr) // [R11]
		else $error("overrun cleared by hardware");

	// no frame can finish while overrun holds the receiver
	a_overrun_quiet: assert property (s_ff.ovr |-> !frame_end_w) // [R10]
		else $error("frame completed during overrun");

	// status read reports availability from the occupancy count
	a_avail_read: assert property (acc_w && !s_ff.pready && !pwrite_i && paddr_i == URX_OFS_STATUS
		|=> prdata_o[URX_ST_AVAIL] == ($past(s_ff.cnt) != '0)) // [R2]
		else $error("data available bit wrong");

	// a status read taken mid-frame shows the receiver busy
	a_idle_read: assert property (acc_w && !s_ff.pready && !pwrite_i && paddr_i == URX_OFS_STATUS
		&& s_ff.st == URX_DATA |=> !prdata_o[URX_ST_IDLE]) // [R15]
		else $error("idle status set during a frame");

	// address words always interrupt, data words never in address mode
	a_addr_irq: assert property (push_w && s_ff.addr_en && s_ff.dps == URX_DPS_9N
		|=> rx_irq_o == $past(s_ff.shf[8])) // [R19]
		else $error("address detect interrupt wrong");

endmodule : urx_top

// *** tb/urx_remote_tx.sv ***
// remote serial transmitter model that drives the receive line
// assumes callers start a frame just after a rising clock edge
`timescale 1ns/100ps
module urx_remote_tx (
	// clock
	input wire logic clk_i,
	// serial line, idle high
	output logic line_o
);
	// clocks per bit: sixteen ticks of divisor plus one clocks
	int bit_clks = 32;
	initial line_o = 1'b1;
	// hold one level for n bit times
	task automatic put(input logic v, input int n);
		line_o <= v;
		repeat (n * bit_clks) @(posedge clk_i);
	endtask : put
	// one frame, lsb first, optional parity, chosen stop levels
	task automatic send(input logic [8:0] d, input int nb, input int par, input logic bad_par,
		input logic [1:0] stp, input int ns);
		logic p;
		p = ^(d & ((9'h001 << nb) - 9'h001)) ^ (par == 2) ^ bad_par;
		put(1'b0, 1);
		for (int i = 0; i < nb; i++) put(d[i], 1);
		if (par != 0) put(p, 1);
		for (int i = 0; i < ns; i++) put(stp[i], 1);
		line_o <= 1'b1;
	endtask : send
endmodule : urx_remote_tx

// *** tb/urx_top_bench.sv ***
// self-checking bench for the serial receiver over apb
// assumes the remote model and the receiver share clk at 250 MHz
`timescale 1ns/100ps
module urx_top_bench import urx_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, loop_on = 1'b0, slv;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	wire logic pready, pslverr, irq, line;
	wire logic [31:0] prdata;
	int err_total = 0, n_compared = 0, n_irq = 0;
	urx_top u_urx_top (.clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
		.pslverr_o(pslverr), .prdata_o(prdata), .rx_pin_i(loop_on ? 1'b1 : line),
		.tx_loop_i(loop_on ? line : 1'b1), .rx_irq_o(irq));
	urx_remote_tx u_urx_remote_tx (.clk_i(clk), .line_o(line));
	// clock and interrupt pulse counter
	initial forever #2 clk = ~clk;
	always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;
	// one apb transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		slv = pslverr;
		if (n >= 20) err_total++;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : xfer
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk
	// send a frame and let the line idle high afterwards
	task automatic tx(input logic [8:0] d, input int nb, input int par, input logic bp,
		input logic [1:0] st, input int ns);
		u_urx_remote_tx.send(d, nb, par, bp, st, ns);
		repeat (40) @(posedge clk);
	endtask : tx
	task automatic close_out();
		if (err_total == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	// watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdchk(URX_OFS_STATUS, 32'h10);
		rdchk(URX_OFS_BAUD, 32'h0);
		rdchk(8'h10, 32'h0);
		chk({31'h0, slv}, 32'h1);
		wr(URX_OFS_BAUD, 32'hFFFF);
		rdchk(URX_OFS_BAUD, 32'hFFFF);
		wr(URX_OFS_BAUD, 32'h1);
		tx(9'h0A5, 8, 0, 1'b0, 2'b11, 1);
		rdchk(URX_OFS_STATUS, 32'h11);
		chk(n_irq, 32'h1);
		rdchk(URX_OFS_DATA, 32'hA5);
		rdchk(URX_OFS_DATA, 32'hA5);
		rdchk(URX_OFS_STATUS, 32'h10);
		// full buffer, then overrun and a refused frame
		wr(URX_OFS_STATUS, 32'hC0);
		for (int i = 1; i < 7; i++) tx(9'(i), 8, 0, 1'b0, 2'b11, 1);
		chk(n_irq, 32'h2);
		rdchk(URX_OFS_STATUS, 32'hD3);
		for (int i = 1; i < 5; i++) rdchk(URX_OFS_DATA, 32'(i));
		wr(URX_OFS_STATUS, 32'h80);
		rdchk(URX_OFS_STATUS, 32'h90);
		for (int i = 0; i < 4; i++) begin
			tx(9'h011, 8, 0, 1'b0, 2'b11, 1);
			chk(n_irq, 32'(2 + (i >= 2)));
		end
		// reset empties the buffer
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdchk(URX_OFS_STATUS, 32'h10);
		wr(URX_OFS_BAUD, 32'h1);
		fork
			tx(9'h00F, 8, 0, 1'b0, 2'b11, 1);
			begin
				repeat (100) @(posedge clk);
				rdchk(URX_OFS_STATUS, 32'h00);
			end
		join
		rdchk(URX_OFS_DATA, 32'h0F);
		wr(URX_OFS_MODE, 32'h2);
		tx(9'h03C, 8, 1, 1'b1, 2'b11, 1);
		rdchk(URX_OFS_STATUS, 32'h19);
		rdchk(URX_OFS_DATA, 32'h3C);
		wr(URX_OFS_MODE, 32'h4);
		tx(9'h03D, 8, 2, 1'b0, 2'b11, 1);
		rdchk(URX_OFS_STATUS, 32'h11);
		rdchk(URX_OFS_DATA, 32'h3D);
		wr(URX_OFS_MODE, 32'h1);
		tx(9'h066, 8, 0, 1'b0, 2'b01, 2);
		tx(9'h067, 8, 0, 1'b0, 2'b11, 2);
		wr(URX_OFS_STATUS, 32'h1C);
		rdchk(URX_OFS_STATUS, 32'h15);
		rdchk(URX_OFS_DATA, 32'h66);
		rdchk(URX_OFS_STATUS, 32'h11);
		rdchk(URX_OFS_DATA, 32'h67);
		// long break, then a continuing low that must not start a frame
		wr(URX_OFS_MODE, 32'h0);
		u_urx_remote_tx.put(1'b0, 20);
		u_urx_remote_tx.put(1'b1, 1);
		chk(n_irq, 32'h9);
		rdchk(URX_OFS_STATUS, 32'h15);
		rdchk(URX_OFS_DATA, 32'h0);
		rdchk(URX_OFS_STATUS, 32'h10);
		// loopback with the pin held high
		wr(URX_OFS_MODE, 32'h8);
		loop_on <= 1'b1;
		tx(9'h05A, 8, 0, 1'b0, 2'b11, 1);
		rdchk(URX_OFS_DATA, 32'h5A);
		loop_on <= 1'b0;
		// address detect in nine-bit mode
		wr(URX_OFS_MODE, 32'h6);
		wr(URX_OFS_STATUS, 32'hE0);
		tx(9'h1AB, 9, 0, 1'b0, 2'b11, 1);
		tx(9'h0AC, 9, 0, 1'b0, 2'b11, 1);
		chk(n_irq, 32'hB);
		rdchk(URX_OFS_DATA, 32'h1AB);
		rdchk(URX_OFS_DATA, 32'h0AC);
		close_out();
	end
endmodule : urx_top_bench
